// [verilog/spm_top.sv]
// Protection monitors: watchdog, bus, halt, spurious and periodic timer
// Assumes an AXI4-Lite master and bus cycle flags on aclk
`timescale 1ns/10ps
`include "spm_map.svh"
//----------------------------------------------------------------
//----------------------------------------------------------------
module spm_top #(
   parameter int WDG_PRESCALE = `SPM_WDG_PRE,
   parameter int PER_PRESCALE = `SPM_WDG_PRE
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [`SPM_AW-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [`SPM_AW-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic clock_mode_pin,
   input wire spm_pkg::spm_cyc_t cyc,
   input wire logic halt_request,
   input wire logic [2:0] ext_request_level,
   input wire logic [2:0] ack_level,
   output logic watchdog_reset,
   output logic halt_reset,
   output logic bus_error,
   output logic [2:0] request_level,
   output logic request_from_timer,
   output logic [7:0] ack_vector,
   output logic spurious_exception
);
   spm_pkg::spm_prot_t system_protection_control_r;
   spm_pkg::spm_periodic_interrupt_control_t periodic_interrupt_control_r;
   spm_pkg::spm_svc_t svc_r;
   spm_pkg::spm_bm_t bm_r;
   logic [3:0] arbitration_priority_field_r;
   logic [8:0] periodic_timer_ctl_r;
   logic [1:0] reset_status_register_r;
   logic prot_locked_r, first_cycle_r, mode_meta_r, mode_sync_r;
   logic [1:0] wdg_tim_act_r;
   logic wdg_pre_act_r;
   logic aw_got_r, w_got_r, arb_latch_r, iack_seen_r, per_pend_r;
   logic [`SPM_AW-1:0] waddr_r;
   logic [31:0] wdata_r, rd_mux;
   logic [3:0] wstrb_r;
   logic [6:0] bm_cnt_r, bm_limit;
   logic aw_hs, w_hs, ar_hs, wr_fire, aw_got_nxt, w_got_nxt;
   logic [11:0] widx, ridx;
   logic wr_svc, svc_done, wdg_en, pre_tick, wdg_tick;
   logic [14:0] wdg_term, wdg_cnt;
   logic bm_watch, bm_ack, spur_err, iack_hit, timer_wins;
   logic per_run, per_pre_tick, per_tick, per_ack;
   logic [7:0] per_cnt;
   logic [2:0] per_lvl;

   function automatic logic mapped(input logic [11:0] idx);
      mapped = idx == `SPM_IDX_PROT_CTL || idx == `SPM_IDX_PER_INT_CTL ||
         idx == `SPM_IDX_RST_STAT || idx == `SPM_IDX_ARB_PRIO ||
         idx == `SPM_IDX_PER_TMR || idx == `SPM_IDX_WDG_SVC;
   endfunction

   //----------------------------------------------------------------
   // Bus slave, write side
   //----------------------------------------------------------------
   assign aw_hs = awvalid & awready;
   assign w_hs = wvalid & wready;
   assign wr_fire = aw_got_r & w_got_r & ~bvalid;
   assign aw_got_nxt = (aw_got_r | aw_hs) & ~wr_fire;
   assign w_got_nxt = (w_got_r | w_hs) & ~wr_fire;
   assign widx = waddr_r[`SPM_AW-1:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awready <= ~aw_got_nxt;
         wready <= ~w_got_nxt;
      end
   end

   always_ff @(posedge aclk) begin
      if (aw_hs) begin
         waddr_r <= awaddr;
      end
      if (w_hs) begin
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `SPM_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid <= 1'b1;
         bresp <= mapped(widx) ? `SPM_RESP_OKAY : `SPM_RESP_DECERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   //----------------------------------------------------------------
   // Bus slave, read side
   //----------------------------------------------------------------
   assign ar_hs = arvalid & arready;
   assign ridx = araddr[`SPM_AW-1:2];

   always_comb begin
      rd_mux = '0;
      case (ridx)
         `SPM_IDX_PROT_CTL: rd_mux[7:0] = system_protection_control_r;
         `SPM_IDX_PER_INT_CTL: rd_mux[10:0] = periodic_interrupt_control_r;
         `SPM_IDX_RST_STAT: rd_mux[1:0] = reset_status_register_r;
         `SPM_IDX_ARB_PRIO: rd_mux[3:0] = arbitration_priority_field_r;
         `SPM_IDX_PER_TMR: rd_mux[8:0] = periodic_timer_ctl_r;
         default: rd_mux = '0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         arready <= 1'b0;
         rdata <= '0;
         rresp <= `SPM_RESP_OKAY;
      end else if (ar_hs) begin
         rvalid <= 1'b1;
         arready <= 1'b0;
         rdata <= rd_mux;
         rresp <= mapped(ridx) ? `SPM_RESP_OKAY : `SPM_RESP_DECERR;
      end else begin
         if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
         arready <= ~rvalid | rready;
      end
   end

   //----------------------------------------------------------------
   // Control registers
   //----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      mode_meta_r <= clock_mode_pin;
      mode_sync_r <= mode_meta_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         system_protection_control_r <= `SPM_PROT_CTL_RST;
         prot_locked_r <= 1'b0;
         first_cycle_r <= 1'b1;
      end else begin
         first_cycle_r <= 1'b0;
         if (first_cycle_r) begin
            system_protection_control_r.watchdog_prescale_bit <= ~mode_sync_r;
         end
         if (wr_fire && widx == `SPM_IDX_PROT_CTL && wstrb_r[0] &&
            !prot_locked_r) begin
            system_protection_control_r <= wdata_r[7:0];
            prot_locked_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         periodic_interrupt_control_r <= `SPM_PER_INT_CTL_RST;
         arbitration_priority_field_r <= `SPM_ARB_PRIO_RST;
         periodic_timer_ctl_r <= `SPM_PER_TMR_RST;
      end else if (wr_fire) begin
         if (widx == `SPM_IDX_PER_INT_CTL && wstrb_r[0]) begin
            periodic_interrupt_control_r[7:0] <= wdata_r[7:0];
         end
         if (widx == `SPM_IDX_PER_INT_CTL && wstrb_r[1]) begin
            periodic_interrupt_control_r[10:8] <= wdata_r[10:8];
         end
         if (widx == `SPM_IDX_ARB_PRIO && wstrb_r[0]) begin
            arbitration_priority_field_r <= wdata_r[3:0];
         end
         if (widx == `SPM_IDX_PER_TMR && wstrb_r[0]) begin
            periodic_timer_ctl_r[7:0] <= wdata_r[7:0];
         end
         if (widx == `SPM_IDX_PER_TMR && wstrb_r[1]) begin
            periodic_timer_ctl_r[8] <= wdata_r[8];
         end
      end
   end

   //----------------------------------------------------------------
   // Watchdog service sequence
   //----------------------------------------------------------------
   assign wr_svc = wr_fire & (widx == `SPM_IDX_WDG_SVC) & wstrb_r[0];
   assign svc_done = wr_svc & (svc_r == spm_pkg::SPM_SVC_ARMED) &
      (wdata_r[7:0] == `SPM_SVC_SECOND);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         svc_r <= spm_pkg::SPM_SVC_IDLE;
      end else if (wr_svc) begin
         case (svc_r)
            spm_pkg::SPM_SVC_IDLE: begin
               if (wdata_r[7:0] == `SPM_SVC_FIRST) begin
                  svc_r <= spm_pkg::SPM_SVC_ARMED;
               end
            end
            spm_pkg::SPM_SVC_ARMED: svc_r <= spm_pkg::SPM_SVC_IDLE;
            default: svc_r <= spm_pkg::SPM_SVC_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdg_tim_act_r <= 2'h0;
         wdg_pre_act_r <= 1'b0;
      end else if (first_cycle_r) begin
         wdg_pre_act_r <= ~mode_sync_r;
      end else if (svc_done) begin
         wdg_tim_act_r <=
            system_protection_control_r.watchdog_timing_field;
         wdg_pre_act_r <=
            system_protection_control_r.watchdog_prescale_bit;
      end
   end

   //----------------------------------------------------------------
   // Watchdog counters
   //----------------------------------------------------------------
   assign wdg_en = system_protection_control_r.watchdog_enable_bit;

   always_comb begin
      case (wdg_tim_act_r)
         2'h0: wdg_term = `SPM_WDG_T0;
         2'h1: wdg_term = `SPM_WDG_T1;
         2'h2: wdg_term = `SPM_WDG_T2;
         default: wdg_term = `SPM_WDG_T3;
      endcase
   end

   spm_cnt #(.W(9)) u_wdg_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(svc_done | ~wdg_en),
      .en(wdg_en & wdg_pre_act_r),
      .term(9'(WDG_PRESCALE - 1)),
      .cnt_r(),
      .tick_r(pre_tick)
   );

   spm_cnt #(.W(15)) u_wdg (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(svc_done | ~wdg_en),
      .en(wdg_en & (wdg_pre_act_r ? pre_tick : 1'b1)),
      .term(wdg_term),
      .cnt_r(wdg_cnt),
      .tick_r(wdg_tick)
   );

   //----------------------------------------------------------------
   // Reset requests and reset status
   //----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_reset <= 1'b0;
         halt_reset <= 1'b0;
         reset_status_register_r <= 2'h0;
      end else begin
         watchdog_reset <= wdg_tick & wdg_en;
         halt_reset <= halt_request &
            system_protection_control_r.halt_monitor_enable;
         if ((wdg_tick & wdg_en) | (halt_request &
            system_protection_control_r.halt_monitor_enable)) begin
            reset_status_register_r <= {halt_request &
               system_protection_control_r.halt_monitor_enable,
               wdg_tick & wdg_en};
         end
      end
   end

   //----------------------------------------------------------------
   // Bus monitor and spurious interrupt monitor
   //----------------------------------------------------------------
   assign bm_watch = cyc.active & cyc.cpu & (~cyc.ext |
      system_protection_control_r.external_bus_monitor_enable);
   assign bm_ack = cyc.size_acknowledge |
      (cyc.iack & cyc.autovector_acknowledge);
   assign spur_err = cyc.active & cyc.iack & (cyc.size_acknowledge |
      cyc.autovector_acknowledge) & ~arb_latch_r & ~cyc.arb_seen;

   always_comb begin
      case (system_protection_control_r.bus_monitor_timing_field)
         2'h0: bm_limit = `SPM_BM_T0;
         2'h1: bm_limit = `SPM_BM_T1;
         2'h2: bm_limit = `SPM_BM_T2;
         default: bm_limit = `SPM_BM_T3;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !cyc.active) begin
         arb_latch_r <= 1'b0;
      end else if (cyc.arb_seen) begin
         arb_latch_r <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bm_r <= spm_pkg::SPM_BM_IDLE;
         bm_cnt_r <= 7'h00;
         bus_error <= 1'b0;
      end else begin
         bus_error <= spur_err;
         case (bm_r)
            spm_pkg::SPM_BM_IDLE: begin
               bm_cnt_r <= 7'h01;
               if (bm_watch && !bm_ack) begin
                  bm_r <= spm_pkg::SPM_BM_WAIT;
               end
            end
            spm_pkg::SPM_BM_WAIT: begin
               if (!bm_watch || bm_ack) begin
                  bm_r <= spm_pkg::SPM_BM_IDLE;
               end else if (bm_cnt_r == bm_limit) begin
                  bm_r <= spm_pkg::SPM_BM_ERR;
                  bus_error <= 1'b1;
               end else begin
                  bm_cnt_r <= bm_cnt_r + 7'h01;
               end
            end
            spm_pkg::SPM_BM_ERR: begin
               if (!cyc.active) begin
                  bm_r <= spm_pkg::SPM_BM_IDLE;
               end else begin
                  bus_error <= 1'b1;
               end
            end
            default: bm_r <= spm_pkg::SPM_BM_IDLE;
         endcase
      end
   end

   //----------------------------------------------------------------
   // Periodic timer
   //----------------------------------------------------------------
   assign per_run = |periodic_timer_ctl_r[7:0];
   assign per_lvl = periodic_interrupt_control_r.periodic_request_level;

   spm_cnt #(.W(9)) u_per_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(~per_run),
      .en(per_run & periodic_timer_ctl_r[`SPM_PER_TMR_PRE_BIT]),
      .term(9'(PER_PRESCALE - 1)),
      .cnt_r(),
      .tick_r(per_pre_tick)
   );

   spm_cnt #(.W(8)) u_per (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(~per_run),
      .en(per_run & (periodic_timer_ctl_r[`SPM_PER_TMR_PRE_BIT] ?
         per_pre_tick : 1'b1)),
      .term(periodic_timer_ctl_r[7:0] - 8'h01),
      .cnt_r(per_cnt),
      .tick_r(per_tick)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_pend_r <= 1'b0;
      end else begin
         if (per_ack) begin
            per_pend_r <= 1'b0;
         end
         if (per_tick && per_lvl != 3'h0) begin
            per_pend_r <= 1'b1;
         end
      end
   end

   //----------------------------------------------------------------
   // Request arbitration and acknowledge
   //----------------------------------------------------------------
   assign timer_wins = per_pend_r & (per_lvl != 3'h0) &
      (per_lvl >= ext_request_level);
   assign iack_hit = cyc.active & cyc.iack & ~iack_seen_r &
      (ack_level == request_level) & (request_level != 3'h0);
   assign per_ack = iack_hit & request_from_timer &
      (arbitration_priority_field_r != 4'h0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iack_seen_r <= 1'b0;
         request_level <= 3'h0;
         request_from_timer <= 1'b0;
         ack_vector <= 8'h00;
         spurious_exception <= 1'b0;
      end else begin
         iack_seen_r <= cyc.active & cyc.iack;
         request_level <= timer_wins ? per_lvl : ext_request_level;
         request_from_timer <= timer_wins;
         spurious_exception <= iack_hit &
            (arbitration_priority_field_r == 4'h0);
         if (per_ack) begin
            ack_vector <= periodic_interrupt_control_r.periodic_vector;
         end
      end
   end

   //----------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------
   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);

   prot_write_once_a: assert property (prot_locked_r |=>
      $stable(system_protection_control_r))
      else $error("protection control changed after lock");
   wdg_disabled_a: assert property (!wdg_en [*2] |=>
      !watchdog_reset)
      else $error("watchdog reset while disabled");
   svc_pair_a: assert property (wr_svc && svc_r == spm_pkg::SPM_SVC_IDLE
      && wdata_r[7:0] == `SPM_SVC_FIRST |=> svc_r == spm_pkg::SPM_SVC_ARMED)
      else $error("first service write not taken");
   svc_restart_a: assert property (svc_done && wdg_en |=>
      wdg_cnt == 15'h0000 ##1 wdg_cnt <= 15'h0001)
      else $error("service did not restart watchdog");
   timeout_reset_a: assert property (wdg_tick && wdg_en |=>
      watchdog_reset && reset_status_register_r[0])
      else $error("timeout without reset");
   svc_reads_zero_a: assert property (ar_hs &&
      ridx == `SPM_IDX_WDG_SVC |=> rvalid && rdata == 32'h0000_0000)
      else $error("service register read not zero");
   halt_gate_a: assert property (halt_request &&
      !system_protection_control_r.halt_monitor_enable |=> !halt_reset)
      else $error("halt reset while monitor disabled");
   halt_flag_a: assert property (halt_reset |->
      reset_status_register_r[1])
      else $error("halt source not recorded");
   bm_limit_a: assert property (bm_r == spm_pkg::SPM_BM_WAIT && bm_watch
      && !bm_ack && bm_cnt_r == bm_limit |=> bus_error)
      else $error("bus error missing at limit");
   spurious_bus_error_a: assert property (spur_err |=> bus_error)
      else $error("spurious iack without bus error");
   timer_runs_a: assert property (per_run &&
      !periodic_timer_ctl_r[`SPM_PER_TMR_PRE_BIT] &&
      periodic_timer_ctl_r[7:0] > 8'h01 |=> per_cnt != $past(per_cnt))
      else $error("periodic timer stalled");
   timer_first_a: assert property (timer_wins |=>
      request_from_timer && request_level == $past(per_lvl))
      else $error("timer request not preferred");

   svc_done_c: cover property (svc_done);
   wdg_reset_c: cover property (watchdog_reset);
   bm_timeout_c: cover property (bm_r == spm_pkg::SPM_BM_ERR);
   spurious_c: cover property (spurious_exception);
endmodule

// [verilog/spm_map.svh]
// Register map, field reset values and cycle counts of the monitors
// Assumes inclusion by bare name from the top module and the bench
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH
`define SPM_AW 14
`define SPM_IDX_PROT_CTL 12'ha21
`define SPM_IDX_PER_INT_CTL 12'ha22
`define SPM_IDX_RST_STAT 12'ha23
`define SPM_IDX_ARB_PRIO 12'ha24
`define SPM_IDX_PER_TMR 12'ha25
`define SPM_IDX_WDG_SVC 12'ha27
`define SPM_SVC_FIRST 8'h55
`define SPM_SVC_SECOND 8'haa
`define SPM_PROT_CTL_RST 8'h80
`define SPM_PER_INT_CTL_RST 11'h00f
`define SPM_ARB_PRIO_RST 4'hf
`define SPM_PER_TMR_RST 9'h000
`define SPM_PER_TMR_PRE_BIT 8
`define SPM_WDG_PRE 512
`define SPM_WDG_T0 15'h01ff
`define SPM_WDG_T1 15'h07ff
`define SPM_WDG_T2 15'h1fff
`define SPM_WDG_T3 15'h7fff
`define SPM_BM_T0 7'h40
`define SPM_BM_T1 7'h20
`define SPM_BM_T2 7'h10
`define SPM_BM_T3 7'h08
`define SPM_RESP_OKAY 2'h0
`define SPM_RESP_DECERR 2'h3
`endif

// [verilog/spm_pkg.sv]
// Types shared by the protection monitor modules
// Assumes the map header for the register constants
package spm_pkg;
   typedef struct packed {
      logic watchdog_enable_bit;
      logic watchdog_prescale_bit;
      logic [1:0] watchdog_timing_field;
      logic halt_monitor_enable;
      logic external_bus_monitor_enable;
      logic [1:0] bus_monitor_timing_field;
   } spm_prot_t;
   typedef struct packed {
      logic [2:0] periodic_request_level;
      logic [7:0] periodic_vector;
   } spm_periodic_interrupt_control_t;
   typedef struct packed {
      logic active;
      logic cpu;
      logic ext;
      logic iack;
      logic size_acknowledge;
      logic autovector_acknowledge;
      logic arb_seen;
   } spm_cyc_t;
   typedef enum logic {
      SPM_SVC_IDLE = 1'b0,
      SPM_SVC_ARMED = 1'b1
   } spm_svc_t;
   typedef enum logic [1:0] {
      SPM_BM_IDLE = 2'b00,
      SPM_BM_WAIT = 2'b01,
      SPM_BM_ERR = 2'b11
   } spm_bm_t;
endpackage

// [verilog/spm_cnt.sv]
// Wrapping counter with terminal count pulse
// Assumes clear and enable from logic on the same clock
`timescale 1ns/10ps
module spm_cnt #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clr,
   input wire logic en,
   input wire logic [W-1:0] term,
   output logic [W-1:0] cnt_r,
   output logic tick_r
);
   //----------------------------------------------------------------
   // Count and wrap
   //----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         cnt_r <= '0;
      end else if (en) begin
         cnt_r <= (cnt_r >= term) ? '0 : cnt_r + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      tick_r <= aresetn & ~clr & en & (cnt_r >= term);
   end
endmodule

// [sim/spm_slave_model.sv]
// Bus slave model: answers a bus cycle with size acknowledge
// Assumes start pulses and settings from the bench on aclk
`timescale 1ns/10ps
module spm_slave_model (
   input wire logic aclk,
   input wire logic start,
   input wire logic cpu,
   input wire logic [7:0] dly,
   input wire logic iack,
   output spm_pkg::spm_cyc_t cyc,
   output logic busy
);
   int n = 0;
   initial cyc = '0;
   initial busy = 0;
   always @(posedge aclk) begin
      if (start) begin
         cyc <= {1'b1, cpu, 1'b0, iack, 3'h0};
         busy <= 1;
         n <= 0;
      end else if (busy) begin
         n <= n + 1;
         cyc.size_acknowledge <= (n == dly);
         if (n == dly + 1) begin
            cyc <= '0;
            busy <= 0;
         end
      end
   end
endmodule

// [sim/system_protection_monitors_tb_top.sv]
// Bench for the protection monitors with a register model
// Assumes the slave model and the map header
`timescale 1ns/10ps
`include "spm_map.svh"
module system_protection_monitors_tb_top;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
   logic awready, wready, bvalid, arready, rvalid, clock_mode_pin = 0;
   logic [13:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] wstrb = 0;
   logic [1:0] bresp, rresp;
   logic halt_request = 0, start = 0, cpu = 0, busy, iack = 0;
   logic request_from_timer, spurious_exception;
   logic [2:0] ext_request_level = 0, ack_level = 0, request_level;
   logic watchdog_reset, halt_reset, bus_error;
   logic [7:0] dly = 0, ack_vector;
   spm_pkg::spm_cyc_t cyc;
   int miscompares = 0, num_checks = 0, seed = 20, wdg = 0;
   int mdl[int];
   bit once = 0;
   spm_top #(.WDG_PRESCALE(4), .PER_PRESCALE(4)) DUT (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(wstrb), .bvalid(bvalid), .bready(1'b1), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(1'b1), .rdata(rdata), .rresp(rresp),
      .clock_mode_pin(clock_mode_pin), .cyc(cyc),
      .halt_request(halt_request), .ext_request_level(ext_request_level),
      .ack_level(ack_level), .watchdog_reset(watchdog_reset),
      .halt_reset(halt_reset), .bus_error(bus_error),
      .request_level(request_level),
      .request_from_timer(request_from_timer), .ack_vector(ack_vector),
      .spurious_exception(spurious_exception));
   spm_slave_model BUS (.aclk(aclk), .start(start), .cpu(cpu), .dly(dly),
      .iack(iack), .cyc(cyc), .busy(busy));
   initial forever #4 aclk = ~aclk;
   always @(posedge aclk) if (watchdog_reset === 1'b1) wdg <= wdg + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int i, input logic [31:0] d);
      awaddr <= 14'(i * 4);
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      chk(bresp, 0);
      case (i)
         `SPM_IDX_PROT_CTL: if (!once) mdl[i] = d[7:0];
         `SPM_IDX_PER_INT_CTL: mdl[i] = d[10:0];
         `SPM_IDX_ARB_PRIO: mdl[i] = d[3:0];
         `SPM_IDX_PER_TMR: mdl[i] = d[8:0];
         default: ;
      endcase
      if (i == `SPM_IDX_PROT_CTL) once = 1;
   endtask
   task automatic rd(input int i);
      araddr <= 14'(i * 4);
      arvalid <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      chk(rdata, mdl.exists(i) ? mdl[i] : 0);
      chk(rresp, mdl.exists(i) ? 0 : 3);
   endtask
   task automatic test_done;
      $display("Checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
   initial begin
      mdl[`SPM_IDX_PROT_CTL] = 8'hc0;
      mdl[`SPM_IDX_PER_INT_CTL] = 11'h00f;
      mdl[`SPM_IDX_RST_STAT] = 0;
      mdl[`SPM_IDX_ARB_PRIO] = 4'hf;
      mdl[`SPM_IDX_PER_TMR] = 0;
      mdl[`SPM_IDX_WDG_SVC] = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      foreach (mdl[i]) rd(i);
      rd(0);
      wr(`SPM_IDX_PER_INT_CTL, $random(seed));
      wr(`SPM_IDX_ARB_PRIO, $random(seed));
      wr(`SPM_IDX_PROT_CTL, 32'h0000_008b);
      wr(`SPM_IDX_PROT_CTL, 32'h0000_0000);
      foreach (mdl[i]) rd(i);
      repeat (7) begin
         wr(`SPM_IDX_WDG_SVC, 32'h0000_0055);
         repeat ({$random(seed)} % 64) @(posedge aclk);
         wr(`SPM_IDX_WDG_SVC, 32'h0000_00aa);
         repeat (300) @(posedge aclk);
      end
      chk(wdg, 0);
      wr(`SPM_IDX_WDG_SVC, 32'h0000_0055);
      wr(`SPM_IDX_WDG_SVC, 32'h0000_0012);
      wr(`SPM_IDX_WDG_SVC, 32'h0000_00aa);
      repeat (250) @(posedge aclk);
      chk(wdg, 1);
      wr(`SPM_IDX_WDG_SVC, 32'h0000_0055);
      wr(`SPM_IDX_WDG_SVC, 32'h0000_00aa);
      @(posedge aclk);
      halt_request <= 1;
      @(posedge aclk);
      halt_request <= 0;
      @(negedge aclk);
      chk(halt_reset, 1);
      @(posedge aclk);
      mdl[`SPM_IDX_RST_STAT] = 2;
      rd(`SPM_IDX_RST_STAT);
      for (int k = 0; k < 3; k++) begin
         cpu <= (k != 1);
         dly <= (k == 2) ? 8'h04 : 8'h1e;
         start <= 1;
         @(posedge aclk);
         start <= 0;
         repeat (12) @(negedge aclk);
         chk(bus_error, k == 0);
         wait (!busy);
         @(posedge aclk);
      end
      wr(`SPM_IDX_PER_INT_CTL,
         32'h0000_0500 | ({$random(seed)} & 32'h0000_00ff));
      wr(`SPM_IDX_PER_TMR, 32'h0000_0010);
      ext_request_level <= 3'h5;
      repeat (40) @(posedge aclk);
      chk(request_from_timer, 1);
      chk(request_level, 5);
      ack_level <= 3'h5;
      iack <= 1;
      cpu <= 1;
      dly <= 8'h04;
      start <= 1;
      @(posedge aclk);
      start <= 0;
      repeat (2) @(negedge aclk);
      chk(spurious_exception, mdl[`SPM_IDX_ARB_PRIO] == 0);
      chk(ack_vector, mdl[`SPM_IDX_ARB_PRIO] ?
         mdl[`SPM_IDX_PER_INT_CTL] & 8'hff : 0);
      repeat (5) @(negedge aclk);
      chk(bus_error, 1);
      test_done;
   end
endmodule
